// file: logic/qdc_pkg.sv
package qdc_pkg;

   localparam int WORD_W     = 12;
   localparam int DATA_W     = 8;
   localparam int CH_N       = 4;
   localparam int FIFO_DEPTH = 4;

   // Word layout, first bit shifted sits in the top field
   typedef struct packed {
      logic [1:0]        channel_select;
      logic [1:0]        command_bit;
      logic [DATA_W-1:0] sample;
   } qdc_word_s;

   typedef struct packed {
      logic sclk;
      logic din;
      logic select_n;
      logic dac_load_strobe_n;
      logic clear_all_n;
      logic shutdown_permit;
   } qdc_pins_s;

   typedef enum logic {QDC_PH_FALL, QDC_PH_RISE} qdc_phase_e;

   typedef logic [CH_N-1:0][DATA_W-1:0] qdc_bank_t;

   localparam qdc_pins_s PINS_IDLE = '{sclk: 1'b0, din: 1'b0,
      select_n: 1'b1, dac_load_strobe_n: 1'b1, clear_all_n: 1'b1,
      shutdown_permit: 1'b0};

   localparam logic [1:0] CMD_LOAD_IN  = 2'h1;
   localparam logic [1:0] CMD_LOAD_UPD = 2'h3;
   localparam logic [3:0] OP_IDLE      = 4'h0;
   localparam logic [3:0] OP_USER_LO   = 4'h2;
   localparam logic [3:0] OP_SW_UPDATE = 4'h4;
   localparam logic [3:0] OP_USER_HI   = 4'h6;
   localparam logic [3:0] OP_LOAD_ALL  = 4'h8;
   localparam logic [3:0] OP_PH_FALL   = 4'ha;
   localparam logic [3:0] OP_SHDN      = 4'hc;
   localparam logic [3:0] OP_PH_RISE   = 4'he;

   localparam qdc_bank_t  BANK_RESET  = '0;
   localparam logic       USER_RESET  = 1'b0;
   localparam qdc_phase_e PHASE_RESET = QDC_PH_FALL;

endpackage : qdc_pkg

// file: logic/qdc_serial_dac_ctrl.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
module qdc_fifo
#(
   parameter int W     = 12,
   parameter int DEPTH = 4
)
(
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_reset,
   // Filling side
   input  wire logic         i_valid,
   output logic              o_ready,
   input  wire logic [W-1:0] i_data,
   // Draining side
   output logic              o_valid,
   input  wire logic         i_ready,
   output logic [W-1:0]      o_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0]  mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0]   count_r;
   logic          push;
   logic          pop;

   assign o_ready = (count_r != (AW+1)'(DEPTH));
   assign o_valid = (count_r != '0);
   assign o_data  = mem_r[rd_ptr_r];
   assign push    = i_valid & o_ready;
   assign pop     = o_valid & i_ready;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == (AW)'(DEPTH-1)) ? '0 : p + (AW)'(1);
   endfunction : bump

   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem_r[wr_ptr_r] <= i_data;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= bump(wr_ptr_r);
         end
         if (pop)
         begin
            rd_ptr_r <= bump(rd_ptr_r);
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule : qdc_fifo

////////////////////////////////////////////////////////////////////////////
module qdc_serial_dac_ctrl
#(
   parameter int FIFO_DEPTH_P = qdc_pkg::FIFO_DEPTH
)
(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_reset,
   // Device pins, all asynchronous to i_clk
   input  wire qdc_pkg::qdc_pins_s i_pins,
   // Serial output toward the next chained device
   output logic                   o_dout,
   // Converter state
   output qdc_pkg::qdc_bank_t     o_dac,
   output logic                   o_shutdown,
   output logic                   o_user_logic_output,
   output logic                   o_phase_rising,
   // Command buffer full, a word arriving now is lost
   output logic                   o_word_busy
);
   import qdc_pkg::*;

   qdc_pins_s  meta_r;
   qdc_pins_s  pin_s;
   logic       sclk_prev_r;
   logic       sel_prev_r;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       sel_rise;
   logic       active;

   logic [WORD_W-1:0] shift_r;
   logic              lag_bit_r;

   logic              fifo_ready;
   logic              fifo_valid;
   logic [WORD_W-1:0] fifo_data;
   logic              exec_ready;
   logic              pop;
   qdc_word_s         word;
   logic [3:0]        op;

   qdc_bank_t  in_r;
   qdc_bank_t  in_nxt;
   qdc_phase_e phase_r;

   function automatic logic is_update(input logic [3:0] code);
      is_update = (code[1:0] == CMD_LOAD_UPD) || (code == OP_SW_UPDATE)
         || (code == OP_PH_RISE) || (code == OP_PH_FALL);
   endfunction : is_update

   function automatic logic loads_input(input logic [1:0] cb);
      loads_input = (cb == CMD_LOAD_IN) || (cb == CMD_LOAD_UPD);
   endfunction : loads_input

   default clocking cb_main @(posedge i_clk); endclocking
   default disable iff (i_reset);

   /////////////////////////////////////////////////////////////////////////
   // Two-stage synchroniser; edges are found on the second stage only
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         meta_r <= PINS_IDLE;
         pin_s  <= PINS_IDLE;
      end
      else
      begin
         meta_r <= i_pins;
         pin_s  <= meta_r;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         sclk_prev_r <= PINS_IDLE.sclk;
         sel_prev_r  <= PINS_IDLE.select_n;
      end
      else
      begin
         sclk_prev_r <= pin_s.sclk;
         sel_prev_r  <= pin_s.select_n;
      end
   end

   assign sclk_rise = pin_s.sclk & ~sclk_prev_r;
   assign sclk_fall = ~pin_s.sclk & sclk_prev_r;
   assign sel_rise  = pin_s.select_n & ~sel_prev_r;
   assign active    = ~pin_s.select_n;

   /////////////////////////////////////////////////////////////////////////
   // Serial shift register
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         shift_r <= '0;
      end
      else if (active && sclk_rise)
      begin
         shift_r <= {shift_r[WORD_W-2:0], pin_s.din};
      end
   end

   a_shift_in: assert property (
      active && sclk_rise |=>
         shift_r == {$past(shift_r[WORD_W-2:0]), $past(pin_s.din)})
      else $error("shift register did not take serial input");

   a_shift_hold: assert property (
      !active |=> $stable(shift_r))
      else $error("shift register moved while deselected");

   /////////////////////////////////////////////////////////////////////////
   // Serial output; the half-clock lag of falling mode needs a held bit
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         lag_bit_r <= 1'b0;
      end
      else if (active && sclk_rise)
      begin
         lag_bit_r <= shift_r[WORD_W-1];
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_dout <= 1'b0;
      end
      else if (active)
      begin
         if (sclk_rise && phase_r == QDC_PH_RISE)
         begin
            o_dout <= shift_r[WORD_W-1];
         end
         else if (sclk_fall && phase_r == QDC_PH_FALL)
         begin
            o_dout <= lag_bit_r;
         end
      end
   end

   a_dout_rise: assert property (
      active && sclk_rise && phase_r == QDC_PH_RISE
         |=> o_dout == $past(shift_r[WORD_W-1]))
      else $error("rising mode output lag wrong");

   a_dout_hold: assert property (
      !active |=> $stable(o_dout))
      else $error("serial output changed while deselected");

   /////////////////////////////////////////////////////////////////////////
   // Words wait here so a burst of select edges is not lost while clear
   // holds the executor; the drain stalls for as long as clear is low
   qdc_fifo #(
      .W     (WORD_W),
      .DEPTH (FIFO_DEPTH_P)
   ) u_fifo (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_valid (sel_rise),
      .o_ready (fifo_ready),
      .i_data  (shift_r),
      .o_valid (fifo_valid),
      .i_ready (exec_ready),
      .o_data  (fifo_data)
   );

   assign exec_ready = pin_s.clear_all_n;
   assign pop        = fifo_valid & exec_ready;
   assign word       = qdc_word_s'(fifo_data);
   assign op         = {word.channel_select, word.command_bit};

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_word_busy <= 1'b0;
      end
      else
      begin
         o_word_busy <= ~fifo_ready;
      end
   end

   a_exec_bound: assert property (
      sel_rise && fifo_ready && pin_s.clear_all_n
         && !fifo_valid |=> pop)
      else $error("word not executed after select edge");

   /////////////////////////////////////////////////////////////////////////
   // Input registers
   always_comb
   begin
      in_nxt = in_r;
      if (pop && loads_input(word.command_bit))
      begin
         in_nxt[word.channel_select] = word.sample;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset || !pin_s.clear_all_n)
      begin
         in_r <= BANK_RESET;
      end
      else
      begin
         in_r <= in_nxt;
      end
   end

   /////////////////////////////////////////////////////////////////////////
   // DAC registers; transparency lags the input register by one cycle
   always_ff @(posedge i_clk)
   begin
      if (i_reset || !pin_s.clear_all_n)
      begin
         o_dac <= BANK_RESET;
      end
      else if (pop && op == OP_LOAD_ALL)
      begin
         o_dac <= {CH_N{word.sample}};
      end
      else if (pop && is_update(op))
      begin
         o_dac <= in_nxt;
      end
      else if (!pin_s.dac_load_strobe_n)
      begin
         o_dac <= in_r;
      end
   end

   a_load_in_only: assert property (
      pop && word.command_bit == CMD_LOAD_IN && pin_s.dac_load_strobe_n
         |=> $stable(o_dac) && in_r[$past(word.channel_select)]
            == $past(word.sample))
      else $error("input-only load disturbed DACs");

   a_load_all: assert property (
      pop && op == OP_LOAD_ALL |=> o_dac == {CH_N{$past(word.sample)}})
      else $error("load-all did not reach every DAC");

   a_idle: assert property (
      pop && op == OP_IDLE && pin_s.dac_load_strobe_n
         && pin_s.clear_all_n |=> $stable(o_dac) && $stable(in_r))
      else $error("idle command changed a register");

   a_transparent: assert property (
      !pin_s.dac_load_strobe_n && pin_s.clear_all_n && !pop
         |=> o_dac == $past(in_r))
      else $error("DACs not transparent with load low");

   a_clear: assert property (
      !pin_s.clear_all_n |=> o_dac == BANK_RESET && in_r == BANK_RESET)
      else $error("clear did not zero registers");

   /////////////////////////////////////////////////////////////////////////
   // Shutdown, user output and output phase
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_shutdown <= 1'b0;
      end
      else if (pop)
      begin
         case (op)
            OP_SHDN:
            begin
               if (pin_s.shutdown_permit)
               begin
                  o_shutdown <= 1'b1;
               end
            end
            OP_SW_UPDATE, OP_LOAD_ALL:
            begin
               o_shutdown <= 1'b0;
            end
            default:
            begin
               o_shutdown <= o_shutdown;
            end
         endcase
      end
   end

   a_shdn: assert property (
      pop && op == OP_SHDN && pin_s.shutdown_permit |=> o_shutdown)
      else $error("permitted shutdown ignored");

   a_shdn_blocked: assert property (
      pop && op == OP_SHDN && !pin_s.shutdown_permit
         |=> $stable(o_shutdown) && $stable(o_dac))
      else $error("blocked shutdown had an effect");

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_user_logic_output <= USER_RESET;
      end
      else if (pop && op == OP_USER_LO)
      begin
         o_user_logic_output <= 1'b0;
      end
      else if (pop && op == OP_USER_HI)
      begin
         o_user_logic_output <= 1'b1;
      end
   end

   a_user_out: assert property (
      pop && (op == OP_USER_LO || op == OP_USER_HI)
         |=> o_user_logic_output == $past(op == OP_USER_HI)
         ##1 (o_user_logic_output == $past(o_user_logic_output)
            || $past(pop)))
      else $error("user output wrong or unstable");

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         phase_r <= PHASE_RESET;
      end
      else if (pop && op == OP_PH_RISE)
      begin
         phase_r <= QDC_PH_RISE;
      end
      else if (pop && op == OP_PH_FALL)
      begin
         phase_r <= QDC_PH_FALL;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_phase_rising <= 1'b0;
      end
      else
      begin
         o_phase_rising <= (phase_r == QDC_PH_RISE);
      end
   end

   a_phase: assert property (
      pop && (op == OP_PH_RISE || op == OP_PH_FALL)
         |=> phase_r == ($past(op) == OP_PH_RISE ? QDC_PH_RISE
            : QDC_PH_FALL) && o_dac == $past(in_nxt))
      else $error("phase command wrong");

   a_phase_hold: assert property (
      !(pop && (op == OP_PH_RISE || op == OP_PH_FALL)) |=> $stable(phase_r))
      else $error("phase changed without command");

endmodule : qdc_serial_dac_ctrl

// file: verif/qdc_host_model.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
module qdc_host_model
(
   // Clock
   input  wire logic i_clk,
   // Serial link
   input  wire logic i_dout,
   output logic      o_sclk,
   output logic      o_din,
   output logic      o_select_n
);

   initial
   begin
      o_sclk     = 1'b0;
      o_din      = 1'b0;
      o_select_n = 1'b1;
   end

   // Half a 200 ns link period, launched just after a system edge
   task automatic half();
      repeat (4) @(posedge i_clk);
      #2;
   endtask : half

   // One whole word per device, data set while the clock is low and
   // taken on its rise
   task automatic send(input  logic [11:0] w,
                       output logic [11:0] hi,
                       output logic [11:0] lo);
      o_select_n = 1'b0;
      for (int k = 0; k < 12; k++)
      begin
         o_din = w[11-k];
         half();
         if (k > 0)
            lo[12-k] = i_dout;
         o_sclk = 1'b1;
         half();
         hi[11-k] = i_dout;
         o_sclk = 1'b0;
      end
      half();
      lo[0] = i_dout;
      o_select_n = 1'b1;
      // Released data line must not look like a held bit
      o_din = ~o_din;
      half();
      half();
   endtask : send

endmodule : qdc_host_model

// file: verif/qdc_serial_dac_ctrl_tb.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
module qdc_serial_dac_ctrl_tb;
   import qdc_pkg::*;

   logic        i_clk       = 1'b0;
   logic        i_reset     = 1'b1;
   logic        strobe_n    = 1'b1;
   logic        clear_n     = 1'b1;
   logic        permit      = 1'b0;
   logic        sclk;
   logic        din;
   logic        sel_n;
   qdc_pins_s   pins;
   logic        o_dout;
   logic        o_shutdown;
   logic        o_user_out;
   logic        o_phase_rising;
   logic        o_word_busy;
   qdc_bank_t   o_dac;
   int          mismatches  = 0;
   int          check_count = 0;
   int          cycles      = 0;
   int          seed        = 97;
   logic [31:0] rnd;
   int          inp[4]      = '{default: 0};
   int          dac[4]      = '{default: 0};
   logic        shdn        = 1'b0;
   logic        user_out    = 1'b0;
   logic        ph          = 1'b0;
   logic [11:0] shreg       = 12'h000;
   logic [11:0] pend[$];

   assign pins = '{sclk: sclk, din: din, select_n: sel_n,
                   dac_load_strobe_n: strobe_n, clear_all_n: clear_n,
                   shutdown_permit: permit};

   always #12.5 i_clk = ~i_clk;

   qdc_serial_dac_ctrl #(.FIFO_DEPTH_P(FIFO_DEPTH)) dut_u
   (
      .i_clk               (i_clk),
      .i_reset             (i_reset),
      .i_pins              (pins),
      .o_dout              (o_dout),
      .o_dac               (o_dac),
      .o_shutdown          (o_shutdown),
      .o_user_logic_output (o_user_out),
      .o_phase_rising      (o_phase_rising),
      .o_word_busy         (o_word_busy)
   );

   qdc_host_model host_u
   (
      .i_clk      (i_clk),
      .i_dout     (o_dout),
      .o_sclk     (sclk),
      .o_din      (din),
      .o_select_n (sel_n)
   );

   /////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (mismatches == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run

   task automatic chk_bit(input string n, input logic e, input logic g);
      check_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk_bit

   task automatic chk_word(input string n, input logic [11:0] e,
                           input logic [11:0] g);
      check_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk_word

   task automatic chk_bank(input string n, input qdc_bank_t e,
                           input qdc_bank_t g);
      check_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk_bank

   /////////////////////////////////////////////////////////////////////////
   function automatic qdc_bank_t exp_bank();
      qdc_bank_t b;
      for (int c = 0; c < CH_N; c++)
         b[c] = dac[c][7:0];
      return b;
   endfunction : exp_bank

   function automatic void apply(input logic [11:0] w);
      int ch;
      int d;
      ch = w[11:10];
      d  = w[7:0];
      if (w[8])
         inp[ch] = d;
      case (w[11:8])
         OP_LOAD_ALL: dac = '{d, d, d, d};
         OP_SHDN:     shdn = shdn | permit;
         OP_USER_LO:  user_out = 1'b0;
         OP_USER_HI:  user_out = 1'b1;
         OP_PH_RISE:  ph = 1'b1;
         OP_PH_FALL:  ph = 1'b0;
         default:     ;
      endcase
      if (w[9:8] == CMD_LOAD_UPD ||
          w[11:8] inside {OP_SW_UPDATE, OP_PH_RISE, OP_PH_FALL})
         dac = inp;
      if (w[11:8] inside {OP_SW_UPDATE, OP_LOAD_ALL})
         shdn = 1'b0;
      // Transparent DAC registers win over a load-all
      if (!strobe_n)
         dac = inp;
   endfunction : apply

   task automatic check_state();
      chk_bank("dac", exp_bank(), o_dac);
      chk_bit("shutdown", shdn, o_shutdown);
      chk_bit("user_out", user_out, o_user_out);
      chk_bit("phase", ph, o_phase_rising);
   endtask : check_state

   task automatic send(input logic [11:0] w);
      logic [11:0] hi;
      logic [11:0] lo;
      host_u.send(w, hi, lo);
      chk_word("dout_lag", shreg, lo);
      if (ph)
         chk_word("dout_rise", shreg, hi);
      else
         chk_word("dout_fall", {1'b0, shreg[11:1]},
                  {1'b0, hi[10:0]});
      chk_bit("dout_hold", lo[0], o_dout);
      shreg = w;
      if (!clear_n)
      begin
         if (pend.size() < FIFO_DEPTH)
            pend.push_back(w);
      end
      else
      begin
         apply(w);
         check_state();
      end
   endtask : send

   /////////////////////////////////////////////////////////////////////////
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         complete_run();
      end
   end

   initial
   begin
      repeat (20) @(posedge i_clk);
      #2;
      i_reset = 1'b0;
      repeat (4) @(posedge i_clk);
      #2;
      check_state();
      chk_bit("busy", 1'b0, o_word_busy);
      // Every code in turn, last pass with transparent DAC registers
      for (int p = 0; p < 3; p++)
      begin
         strobe_n = (p < 2);
         if (p == 2)
            dac = inp;
         for (int op = 0; op < 16; op++)
         begin
            rnd    = $random(seed);
            permit = (op[3:0] == OP_SHDN) ? (p != 1) : rnd[8];
            send({op[3:0], rnd[7:0]});
         end
      end
      // Clear stalls execution, so the buffer fills and refuses
      strobe_n = 1'b1;
      clear_n  = 1'b0;
      inp      = '{default: 0};
      dac      = '{default: 0};
      repeat (4) @(posedge i_clk);
      #2;
      check_state();
      for (int n = 0; n < 5; n++)
      begin
         rnd = $random(seed);
         send({n[1:0], (n >= 3) ? 2'h3 : 2'h1, rnd[7:0]});
      end
      chk_bit("busy", 1'b1, o_word_busy);
      clear_n = 1'b1;
      repeat (10) @(posedge i_clk);
      #2;
      while (pend.size() > 0)
         apply(pend.pop_front());
      check_state();
      chk_bit("busy", 1'b0, o_word_busy);
      complete_run();
   end

endmodule : qdc_serial_dac_ctrl_tb
